// ---- rtl/smbus_cfg_dev.sv ----
/*
 configuration slave of a clock generator with output drive gating.
 assumes clk at 40 MHz; link and control pins are asynchronous;
 se_clk and df_clk are running clocks from logic on clk.
*/
`timescale 1ns/100ps
module smbus_cfg_dev
   import smbus_cfg_pkg::*;
#(
   parameter int             NSE          = 2,
   parameter int             NDF          = 3,
   parameter logic [NSE-1:0] SE_STOPPABLE = 2'b01,
   parameter logic [NDF-1:0] DF_STOPPABLE = 3'b110,
   parameter int             PAIR2_IDX    = 0
) (
   input  logic             clk,
   input  logic             reset,
   smbus_if.device          bus,
   input  logic [NSE-1:0]   se_clk,
   input  logic [NDF-1:0]   df_clk,
   input  logic             pci_stop_n,
   input  logic             cpu_stop_n,
   input  logic             clock_request_n,
   input  logic             power_down_n,
   input  logic             management_low_power_state,
   input  logic             strap_hiz,
   output logic [NSE-1:0]   se_out,
   output logic [NSE-1:0]   se_out_oe_n,
   output logic [NDF-1:0]   df_true,
   output logic [NDF-1:0]   df_comp,
   output logic             latches_open
);
   typedef enum logic [2:0] {
      s_idle, s_addr, s_cmd, s_cnt, s_wr, s_rd, s_ign
   } slave_st_e;

   logic [7:0]        sy1_r, sy2_r, byte_in, tx_r, rd_byte;
   logic [7:0]        cfg_r [NUM_CFG];
   logic              scl_q_r, sda_q_r, scl_s, sda_s, start, stop, rise, fall;
   logic              pci_stop, cpu_stop, creq, pwr_dn, mlps, strap, clr;
   logic              blk_r, ack_r, drv_r, wr_now;
   slave_st_e         st_r;
   logic [3:0]        bit_r;
   logic [6:0]        sh_r, idx_r;

   // pin synchronisers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sy1_r <= 8'hff;
         sy2_r <= 8'hff;
      end else begin
         sy1_r <= {bus.scl, bus.sda, pci_stop_n, cpu_stop_n, clock_request_n,
                   power_down_n, ~management_low_power_state, ~strap_hiz};
         sy2_r <= sy1_r;
      end
   end

   assign scl_s    = sy2_r[7];
   assign sda_s    = sy2_r[6];
   assign pci_stop = ~sy2_r[5];
   assign cpu_stop = ~sy2_r[4];
   assign creq     = ~sy2_r[3];
   assign pwr_dn   = ~sy2_r[2];
   assign mlps     = ~sy2_r[1];
   assign strap    = ~sy2_r[0];
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl_s;
         sda_q_r <= sda_s;
      end
   end
   assign start   = scl_s & scl_q_r & sda_q_r & ~sda_s;
   assign stop    = scl_s & scl_q_r & ~sda_q_r & sda_s;
   assign rise    = scl_s & ~scl_q_r;
   assign fall    = ~scl_s & scl_q_r;
   assign byte_in = {sh_r, sda_s};
   assign clr     = pwr_dn & ~cfg_r[0][RESTORE_BIT];
   assign rd_byte = (idx_r < 7'(NUM_CFG)) ?
                    cfg_r[idx_r[CFG_IW-1:0]] : 8'h00;

   // slave protocol engine
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r  <= s_idle;
         bit_r <= 4'h0;
         sh_r  <= 7'h00;
         tx_r  <= 8'h00;
         idx_r <= 7'h00;
         blk_r <= 1'b0;
         ack_r <= 1'b0;
      end else if (clr || stop) begin
         st_r  <= s_idle;
         ack_r <= 1'b0;
      end else if (start) begin
         st_r  <= s_addr;
         bit_r <= 4'h0;
         ack_r <= 1'b0;
      end else if (rise && st_r != s_idle && st_r != s_ign) begin
         if (bit_r != 4'h8) begin
            sh_r  <= byte_in[6:0];
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'h7) begin
               ack_r <= 1'b1;
               unique case (st_r)
                  s_addr: begin
                     if (byte_in[7:1] != SLAVE_ADDR[7:1]) begin
                        ack_r <= 1'b0;
                        st_r  <= s_ign;
                     end else if (byte_in[0]) begin
                        st_r <= s_rd;
                        if (blk_r) begin
                           tx_r <= NUM_CFG_BYTE;
                        end else begin
                           tx_r  <= rd_byte;
                           idx_r <= idx_r + 7'h01;
                        end
                     end else begin
                        st_r <= s_cmd;
                     end
                  end
                  s_cmd: begin
                     if (byte_in == CMD_BLOCK) begin
                        blk_r <= 1'b1;
                        idx_r <= 7'h00;
                        st_r  <= s_cnt;
                     end else if (byte_in[CMD_BYTE_BIT]) begin
                        blk_r <= 1'b0;
                        idx_r <= byte_in[6:0];
                        st_r  <= s_wr;
                     end else begin
                        ack_r <= 1'b0;
                        st_r  <= s_ign;
                     end
                  end
                  s_cnt: st_r <= s_wr;
                  s_wr: idx_r <= idx_r + 7'h01;
                  s_rd: ack_r <= 1'b0;
                  s_idle, s_ign: ;
               endcase
            end
         end else begin
            bit_r <= 4'h0;
            ack_r <= 1'b0;
            if (st_r == s_rd && !ack_r) begin
               if (sda_s) begin
                  st_r <= s_ign;
               end else begin
                  tx_r  <= rd_byte;
                  idx_r <= idx_r + 7'h01;
               end
            end
         end
      end
   end

   assign wr_now = rise && bit_r == 4'h7 && st_r == s_wr && !start &&
                   !stop && idx_r < 7'(NUM_CFG);

   // configuration bytes
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NUM_CFG; i++) begin
            cfg_r[i] <= CFG_DEFAULT[i];
         end
      end else if (clr) begin
         for (int i = 0; i < NUM_CFG; i++) begin
            cfg_r[i] <= CFG_DEFAULT[i];
         end
      end else if (wr_now) begin
         cfg_r[idx_r[CFG_IW-1:0]] <= byte_in;
      end
   end

   // data and acknowledge drive, changed on scl falling edges
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         drv_r <= 1'b0;
      end else if (clr || start || stop) begin
         drv_r <= 1'b0;
      end else if (fall) begin
         if (bit_r == 4'h8) begin
            drv_r <= ack_r;
         end else begin
            drv_r <= (st_r == s_rd) & ~tx_r[3'h7 - bit_r[2:0]];
         end
      end
   end

   assign bus.d_sda_o    = 1'b0;
   assign bus.d_sda_oe_n = ~drv_r;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         latches_open <= 1'b0;
      end else if (clr) begin
         latches_open <= 1'b1;
      end else if (!pwr_dn) begin
         latches_open <= 1'b0;
      end
   end

   // single-ended output gating
   for (genvar i = 0; i < NSE; i++) begin : g_se
      logic park_r, pwr;
      assign pwr = pwr_dn | latches_open | mlps;
      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            park_r         <= 1'b1;
            se_out[i]      <= 1'b0;
            se_out_oe_n[i] <= 1'b0;
         end else begin
            if (pwr) begin
               park_r <= 1'b1;
            end else if (!se_clk[i]) begin
               park_r <= SE_STOPPABLE[i] & (pci_stop |
                         ~cfg_r[OE_SE_BYTE][i]);
            end
            se_out[i]      <= ~park_r & se_clk[i];
            se_out_oe_n[i] <= pwr & strap;
         end
      end
   end

   // differential pair gating
   for (genvar j = 0; j < NDF; j++) begin : g_df
      logic park_r, high_r, pwr;
      assign pwr = pwr_dn | latches_open | (mlps & (j != PAIR2_IDX));
      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            park_r     <= 1'b1;
            high_r     <= 1'b0;
            df_true[j] <= 1'b0;
            df_comp[j] <= 1'b0;
         end else begin
            if (pwr) begin
               park_r <= 1'b1;
               high_r <= 1'b0;
            end else if (!df_clk[j]) begin
               park_r <= DF_STOPPABLE[j] & (~cfg_r[OE_DF_BYTE][j] | creq |
                         pci_stop | cpu_stop);
               high_r <= cfg_r[OE_DF_BYTE][j] & ~creq &
                         (pci_stop | cpu_stop);
            end
            df_true[j] <= park_r ? high_r : df_clk[j];
            df_comp[j] <= ~park_r & ~df_clk[j];
         end
      end
   end
endmodule : smbus_cfg_dev

// ---- rtl/smbus_cfg_pkg.sv ----
/*
 constants shared by both ends of the configuration serial link:
 addresses, command codes, byte layout, defaults and timing.
 assumes a single 40 MHz system clock at each end.
*/
package smbus_cfg_pkg;
   localparam logic [7:0] SLAVE_ADDR    = 8'hd2;
   localparam logic [7:0] CMD_BLOCK     = 8'h00;
   localparam int         CMD_BYTE_BIT  = 7;
   localparam int         NUM_CFG       = 8;
   localparam int         CFG_IW        = $clog2(NUM_CFG);
   localparam logic [7:0] NUM_CFG_BYTE  = 8'h08;
   localparam int         RESTORE_BIT   = 0;
   localparam int         OE_SE_BYTE    = 1;
   localparam int         OE_DF_BYTE    = 2;
   localparam logic [7:0] CFG_DEFAULT [NUM_CFG] = '{
      8'h01, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   // serial link reference clock divider programming limits
   localparam int SLRC_N_BASE_OFF  = 442;
   localparam int SLRC_N_BASE_DOWN = 413;
   localparam int SLRC_M_OFF       = 14;
   localparam int SLRC_M_DOWN      = 13;
   localparam int SLRC_N_MAX_OFF   = 536;
   localparam int SLRC_N_MAX_DOWN  = 502;
   localparam int CLK_HZ          = 40_000_000;
   localparam int SCL_HZ          = 100_000;
   localparam int SCL_QTR         = CLK_HZ / (4 * SCL_HZ);
endpackage : smbus_cfg_pkg

// ---- rtl/smbus_if.sv ----
/*
 two-wire link between host master and configuration slave.
 assumes pull-ups: a released line reads high.
*/
`timescale 1ns/100ps
interface smbus_if;
   logic h_scl_o;
   logic h_scl_oe_n;
   logic h_sda_o;
   logic h_sda_oe_n;
   logic d_sda_o;
   logic d_sda_oe_n;
   logic scl;
   logic sda;
   assign scl = h_scl_oe_n ? 1'b1 : h_scl_o;
   assign sda = (h_sda_oe_n ? 1'b1 : h_sda_o) &
                (d_sda_oe_n ? 1'b1 : d_sda_o);
   modport host (input scl, input sda, output h_scl_o, output h_scl_oe_n,
                 output h_sda_o, output h_sda_oe_n);
   modport device (input scl, input sda, output d_sda_o,
                   output d_sda_oe_n);
endinterface : smbus_if

// ---- rtl/smbus_cfg_host.sv ----
/*
 host master for the configuration link: block and byte transfers.
 assumes clk at 40 MHz; the slave does not stretch scl.
*/
`timescale 1ns/100ps
module smbus_cfg_host
   import smbus_cfg_pkg::*;
#(
   parameter int QTR = SCL_QTR
) (
   input  logic       clk,
   input  logic       reset,
   smbus_if.host      bus,
   input  logic       req,
   input  logic       rd,
   input  logic       blk,
   input  logic [6:0] offset,
   input  logic [7:0] len,
   input  logic [7:0] wr_data,
   output logic       wr_take,
   output logic [7:0] rd_data,
   output logic       rd_valid,
   output logic       busy,
   output logic       done,
   output logic       nack
);
   typedef enum logic [1:0] {h_idle, h_start, h_bits, h_stop} host_st_e;
   typedef enum logic [2:0] {g_aw, g_cm, g_bc, g_wd, g_ar, g_rd} stage_e;

   host_st_e   st_r;
   stage_e     stg_r;
   logic [15:0] cnt_r;
   logic       tick;
   logic [1:0] ph_r;
   logic [3:0] bit_r;
   logic [7:0] tx_r;
   logic [7:0] rx_r;
   logic [8:0] left_r;
   logic       rd_r;
   logic       blk_r;
   logic       scl_r;
   logic       sda_r;
   logic       got_nack_r;
   logic [1:0] sy_r;
   logic       send;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sy_r <= 2'b11;
      end else begin
         sy_r <= {sy_r[0], bus.sda};
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_r <= 16'h0000;
      end else if (tick || st_r == h_idle) begin
         cnt_r <= 16'h0000;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   assign tick = cnt_r == 16'(QTR - 1);
   assign send = stg_r != g_rd;
   assign busy = st_r != h_idle;
   assign bus.h_scl_o    = 1'b0;
   assign bus.h_scl_oe_n = scl_r;
   assign bus.h_sda_o    = 1'b0;
   assign bus.h_sda_oe_n = sda_r;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r <= h_idle;
         stg_r <= g_aw;
         ph_r <= 2'h0;
         bit_r <= 4'h0;
         tx_r <= 8'h00;
         rx_r <= 8'h00;
         left_r <= 9'h000;
         rd_r <= 1'b0;
         blk_r <= 1'b0;
         scl_r <= 1'b1;
         sda_r <= 1'b1;
         got_nack_r <= 1'b0;
         wr_take <= 1'b0;
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         done <= 1'b0;
         nack <= 1'b0;
      end else begin
         wr_take  <= 1'b0;
         rd_valid <= 1'b0;
         done     <= 1'b0;
         if (st_r == h_idle) begin
            if (req) begin
               st_r   <= h_start;
               stg_r  <= g_aw;
               ph_r   <= 2'h0;
               rd_r   <= rd;
               blk_r  <= blk;
               left_r <= blk ? {1'b0, len} : 9'h001;
               tx_r   <= {SLAVE_ADDR[7:1], 1'b0};
               nack   <= 1'b0;
            end
         end else if (tick) begin
            ph_r <= ph_r + 2'h1;
            unique case (st_r)
               h_start: begin
                  unique case (ph_r)
                     2'h0: sda_r <= 1'b1;
                     2'h1: scl_r <= 1'b1;
                     2'h2: sda_r <= 1'b0;
                     2'h3: begin
                        scl_r <= 1'b0;
                        st_r  <= h_bits;
                        bit_r <= 4'h0;
                     end
                  endcase
               end
               h_stop: begin
                  unique case (ph_r)
                     2'h0: sda_r <= 1'b0;
                     2'h1: scl_r <= 1'b1;
                     2'h2: sda_r <= 1'b1;
                     2'h3: begin
                        st_r <= h_idle;
                        done <= 1'b1;
                     end
                  endcase
               end
               h_bits: begin
                  unique case (ph_r)
                     2'h0: begin
                        if (bit_r != 4'h8) begin
                           sda_r <= ~send | tx_r[3'h7 - bit_r[2:0]];
                        end else begin
                           sda_r <= send | (left_r == 9'h001);
                        end
                     end
                     2'h1: scl_r <= 1'b1;
                     2'h2: begin
                        if (bit_r != 4'h8) begin
                           rx_r <= {rx_r[6:0], sy_r[1]};
                        end else begin
                           got_nack_r <= send & sy_r[1];
                        end
                     end
                     2'h3: begin
                        scl_r <= 1'b0;
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == 4'h8) begin
                           bit_r <= 4'h0;
                           if (got_nack_r) begin
                              nack <= 1'b1;
                              st_r <= h_stop;
                           end else begin
                              unique case (stg_r)
                                 g_aw: begin
                                    stg_r <= g_cm;
                                    tx_r  <= blk_r ? CMD_BLOCK :
                                             {1'b1, offset};
                                 end
                                 g_cm: begin
                                    if (rd_r) begin
                                       stg_r <= g_ar;
                                       st_r  <= h_start;
                                       tx_r  <= {SLAVE_ADDR[7:1], 1'b1};
                                    end else if (blk_r) begin
                                       stg_r <= g_bc;
                                       tx_r  <= len;
                                    end else begin
                                       stg_r   <= g_wd;
                                       tx_r    <= wr_data;
                                       wr_take <= 1'b1;
                                    end
                                 end
                                 g_bc: begin
                                    if (left_r == 9'h000) begin
                                       st_r <= h_stop;
                                    end else begin
                                       stg_r   <= g_wd;
                                       tx_r    <= wr_data;
                                       wr_take <= 1'b1;
                                    end
                                 end
                                 g_wd: begin
                                    if (left_r == 9'h001) begin
                                       st_r <= h_stop;
                                    end else begin
                                       left_r  <= left_r - 9'h001;
                                       tx_r    <= wr_data;
                                       wr_take <= 1'b1;
                                    end
                                 end
                                 g_ar: begin
                                    stg_r  <= g_rd;
                                    left_r <= blk_r ? {1'b0, len} + 9'h001
                                                    : 9'h001;
                                 end
                                 g_rd: begin
                                    rd_data  <= rx_r;
                                    rd_valid <= 1'b1;
                                    left_r   <= left_r - 9'h001;
                                    if (left_r == 9'h001) begin
                                       st_r <= h_stop;
                                    end
                                 end
                              endcase
                           end
                        end
                     end
                  endcase
               end
               h_idle: ;
            endcase
         end
      end
   end
endmodule : smbus_cfg_host

// ---- tb/smbus_cfg_assertions.sv ----
/*
 link checker: timing and ownership of the two-wire lines.
 assumes clk at 40 MHz and a host quarter period of 4 clk.
*/
`timescale 1ns/100ps
module smbus_cfg_assertions (
   input wire logic clk,
   input wire logic reset,
   input wire logic h_scl_oe_n,
   input wire logic h_sda_oe_n,
   input wire logic d_sda_oe_n,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   chk_dev_drive_low: assert property (
      $changed(d_sda_oe_n) |-> !scl)
      else $error("device sda moved while scl high");
   chk_scl_low_min: assert property (
      $fell(scl) |-> !scl [*4])
      else $error("scl low phase too short");
   chk_scl_high_min: assert property (
      $rose(scl) |-> scl [*4])
      else $error("scl high phase too short");
   chk_addr_acked: assert property (
      scl && $fell(sda) |-> ##[1:200] !d_sda_oe_n)
      else $error("own address not acknowledged");
   chk_addr_quiet: assert property (
      scl && $fell(sda) |-> d_sda_oe_n [*8])
      else $error("device drove sda during address");
   chk_stop_release: assert property (
      scl && $rose(sda) |=> d_sda_oe_n [*8])
      else $error("device drove sda after stop");
   chk_reset_idle: assert property (
      $fell(reset) |-> d_sda_oe_n && h_scl_oe_n && h_sda_oe_n)
      else $error("lines not released after reset");
   chk_bit_stands: assert property (
      $rose(scl) && !d_sda_oe_n |-> !d_sda_oe_n [*4])
      else $error("device bit not held through scl high");
endmodule : smbus_cfg_assertions

// ---- tb/tb_top.sv ----
/*
 bench for host and configuration slave joined by the link interface.
 assumes QTR of 4 and the package defaults for the configuration bytes.
*/
`timescale 1ns/100ps
module tb_top;
   import smbus_cfg_pkg::*;
   logic       clk, reset, req, rd, blk, wr_take, rd_valid, done, nack;
   logic       pci_stop_n, cpu_stop_n, clock_request_n, power_down_n;
   logic       management_low_power_state, strap_hiz, latches_open;
   logic [6:0] offset;
   logic [7:0] len, wr_data, rd_data;
   logic [1:0] se_out, se_out_oe_n, sc;
   logic [2:0] df_true, df_comp;
   int         bad_count, cmp_count, seed, k, m[8], n_div;
   logic [7:0] wq[$], rq[$];
   smbus_if bus_if ();
   smbus_cfg_host #(.QTR(4)) smbus_cfg_host_inst (.clk(clk), .reset(reset),
      .bus(bus_if.host), .req(req), .rd(rd), .blk(blk), .offset(offset),
      .len(len), .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data),
      .rd_valid(rd_valid), .busy(), .done(done), .nack(nack));
   smbus_cfg_dev smbus_cfg_dev_inst (.clk(clk), .reset(reset),
      .bus(bus_if.device), .se_clk({2{sc[1]}}), .df_clk({3{sc[1]}}),
      .pci_stop_n(pci_stop_n), .cpu_stop_n(cpu_stop_n),
      .clock_request_n(clock_request_n), .power_down_n(power_down_n),
      .management_low_power_state(management_low_power_state),
      .strap_hiz(strap_hiz), .se_out(se_out), .se_out_oe_n(se_out_oe_n),
      .df_true(df_true), .df_comp(df_comp), .latches_open(latches_open));
   smbus_cfg_assertions smbus_cfg_assertions_inst (.clk(clk),
      .reset(reset), .h_scl_oe_n(bus_if.h_scl_oe_n),
      .h_sda_oe_n(bus_if.h_sda_oe_n), .d_sda_oe_n(bus_if.d_sda_oe_n),
      .scl(bus_if.scl), .sda(bus_if.sda));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(negedge clk) begin
      sc <= reset ? 2'b00 : sc + 2'b01;
      if (wr_take === 1'b1) begin
         wr_data = (k < wq.size()) ? wq[k] : 8'h00;
         k++;
      end
      if (rd_valid === 1'b1) rq.push_back(rd_data);
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [7:0] e, s);
      cmp_count++;
      if (e !== s) begin
         $display("Error %s expected %h seen %h", nm, e, s);
         bad_count++;
      end
   endtask : chk
   task automatic xfer(input logic r, b, input logic [6:0] o,
                       input logic [7:0] n);
      int t;
      rq.delete();
      k = 1;
      wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
      {rd, blk, offset, len, req} = {r, b, o, n, 1'b1};
      @(negedge clk);
      req = 1'b0;
      for (t = 0; t < 9000 && done !== 1'b1; t++) @(negedge clk);
      if (t == 9000) begin
         bad_count++;
         summarize();
      end
      chk("nack", 8'h00, {7'h0, nack});
   endtask : xfer
   task automatic rblk(input int n);
      xfer(1'b1, 1'b1, 7'h00, n[7:0]);
      chk("size", n[7:0] + 8'h01, rq.size());
      chk("count", NUM_CFG_BYTE, rq[0]);
      for (int i = 0; i < n; i++) chk("cfg", m[i][7:0], rq[i+1]);
   endtask : rblk
   task automatic wt;
      repeat (12) @(negedge clk);
   endtask : wt
   initial begin
      seed = 28401;
      reset = 1'b1;
      {req, rd, blk, offset, len, wr_data} = 26'h0;
      {pci_stop_n, cpu_stop_n, clock_request_n, power_down_n} = 4'hf;
      {management_low_power_state, strap_hiz} = 2'b00;
      bad_count = 0;
      cmp_count = 0;
      k = 0;
      foreach (m[i]) m[i] = CFG_DEFAULT[i];
      repeat (16) @(negedge clk);
      reset = 1'b0;
      repeat (8) @(negedge clk);
      rblk(8);
      m[1] = 8'hfe;
      n_div = (50000 + 1193) / 2386 + SLRC_N_BASE_DOWN;
      chk("ndiv", 8'h00, {7'h0, n_div > SLRC_N_MAX_DOWN});
      m[3] = n_div & 255;
      m[4] = SLRC_M_DOWN;
      for (int i = 5; i < 8; i++) m[i] = $random(seed) & 255;
      foreach (m[i]) wq.push_back(m[i][7:0]);
      xfer(1'b0, 1'b1, 7'h00, 8'h08);
      rblk(3);
      rblk(8);
      m[5] = $random(seed) & 255;
      wq = {m[5][7:0]};
      xfer(1'b0, 1'b0, 7'h05, 8'h01);
      xfer(1'b1, 1'b0, 7'h05, 8'h01);
      chk("byte", m[5][7:0], rq[0]);
      wt();
      chk("oe", 8'h00, {6'h0, se_out[0], se_out_oe_n[0]});
      pci_stop_n = 1'b0;
      wt();
      chk("pci", 8'h0c, {4'h0, df_true[2:1], df_comp[2:1]});
      {pci_stop_n, cpu_stop_n} = 2'b10;
      wt();
      chk("cpu", 8'h0c, {4'h0, df_true[2:1], df_comp[2:1]});
      {cpu_stop_n, clock_request_n} = 2'b10;
      wt();
      chk("creq", 8'h00, {4'h0, df_true[2:1], df_comp[2:1]});
      {clock_request_n, management_low_power_state, strap_hiz} = 3'b111;
      wt();
      chk("mlps", 8'h03, {6'h0, se_out_oe_n});
      {management_low_power_state, power_down_n} = 2'b00;
      wt();
      chk("pwrdn", 8'h00, {1'b0, latches_open, df_true, df_comp});
      {power_down_n, strap_hiz} = 2'b10;
      wt();
      wq = {8'h00};
      xfer(1'b0, 1'b0, 7'h00, 8'h01);
      power_down_n = 1'b0;
      wt();
      chk("lopen", 8'h01, {7'h0, latches_open});
      power_down_n = 1'b1;
      wt();
      foreach (m[i]) m[i] = CFG_DEFAULT[i];
      rblk(8);
      summarize();
   end
endmodule : tb_top
